// file: shared/ldr_pkg.sv
/*
 * Shared constants for the dimming register bank of channels 7 to 12:
 * register addresses, field positions, reset values and counter wrap point.
 * Assumes a byte-addressed register port driven by the serial host logic.
 */
package ldr_pkg;
   // ---------------------------------------------------------------
   // register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] LDR_ADDR_CH7 = 8'h48;
   localparam logic [7:0] LDR_ADDR_CH8 = 8'h49;
   localparam logic [7:0] LDR_ADDR_CH9 = 8'h4a;
   localparam logic [7:0] LDR_ADDR_CH10 = 8'h4b;
   localparam logic [7:0] LDR_ADDR_CH11 = 8'h4c;
   localparam logic [7:0] LDR_ADDR_CH12 = 8'h4d;
   // ---------------------------------------------------------------
   // fields
   // ---------------------------------------------------------------
   localparam int LDR_NUM_CH = 6;
   localparam int LDR_DUTY_W = 12;
   localparam int LDR_DUTY_MSB = 11;
   localparam int LDR_DIS_BIT = 12;
   localparam int LDR_REG_W = 13;
   localparam logic [12:0] LDR_REG_RESET = 13'h0000;
   localparam logic [11:0] LDR_DUTY_OFF = 12'h000;
   localparam logic [11:0] LDR_DUTY_FULL = 12'hfff;
   // period counter wraps after count ffe: 4095 steps per period
   localparam logic [11:0] LDR_CNT_LAST = 12'hffe;
endpackage

// file: rtl/ldr_bank.sv
/*
 * Dimming register bank for bypass channels 7 to 12 with a per-channel
 * comparator against a free-running period counter.
 * Assumes a simple register port from the host interface logic on the
 * same clock; reads are combinational from stored values.
 */
// Operation
// - Bits 11:0 hold the duty code; code zero keeps the output off.
// - Code one gives 1/4095 on-time; all-ones gives full on-time.
// - Bit 12 set raises dim_disabled for the channel; dim_out keeps dimming either way.
// - Six read/write registers at 0x48..0x4D in channel order; reads return writes.
`timescale 1ns/100ps
`default_nettype none
module ldr_bank
   import ldr_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [12:0] reg_wdata,
   output logic [12:0] reg_rdata,
   output logic reg_hit,
   // per-channel outputs, index 0 is channel 7; period_start is shared by all channels
   output logic [5:0] dim_out,
   output logic [5:0] dim_disabled,
   output logic period_start
);
   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // maps an address to channel index, 7 when unmapped
   function automatic logic [2:0] ch_index(input logic [7:0] a);
      logic [2:0] r;
      r = 3'h7;
      if (a >= LDR_ADDR_CH7 && a <= LDR_ADDR_CH12) begin
         r = 3'(a - LDR_ADDR_CH7);
      end
      return r;
   endfunction

   logic [2:0] sel;
   assign sel = ch_index(reg_addr);
   assign reg_hit = (sel != 3'h7);

   // ---------------------------------------------------------------
   // registers and period counter
   // ---------------------------------------------------------------
   logic [12:0] regs [0:5];
   logic [12:0] next_regs [0:5];
   logic [11:0] act_duty [0:5];
   logic [11:0] next_act_duty [0:5];
   logic [11:0] cnt;
   logic [11:0] next_cnt;
   logic [5:0] next_dim_out;

   // register writes, counter, shadow load at period boundary
   always_comb begin
      next_cnt = (cnt == LDR_CNT_LAST) ? 12'h000 : cnt + 12'h001;
      for (int i = 0; i < LDR_NUM_CH; i++) begin
         next_regs[i] = regs[i];
         if (reg_wr && sel == 3'(i)) begin
            next_regs[i] = reg_wdata;
         end
         // shadow avoids a glitched period when software rewrites mid-period
         next_act_duty[i] = (next_cnt == 12'h000) ? next_regs[i][LDR_DUTY_MSB:0]
                                                  : act_duty[i];
         // count 0..4094: duty N is on for N counts; fff is on all 4095
         next_dim_out[i] = (next_act_duty[i] == LDR_DUTY_FULL) ||
                           (next_cnt < next_act_duty[i]);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 12'h000;
         dim_out <= 6'h00;
         for (int i = 0; i < LDR_NUM_CH; i++) begin
            regs[i] <= LDR_REG_RESET;
            act_duty[i] <= LDR_DUTY_OFF;
         end
      end else begin
         cnt <= next_cnt;
         dim_out <= next_dim_out;
         for (int i = 0; i < LDR_NUM_CH; i++) begin
            regs[i] <= next_regs[i];
            act_duty[i] <= next_act_duty[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // status and read path
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < LDR_NUM_CH; i++) begin
         dim_disabled[i] = regs[i][LDR_DIS_BIT];
      end
      reg_rdata = reg_hit ? regs[sel] : 13'h0000;
      period_start = (cnt == 12'h000);
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // per-channel views of the live duty code; they feed only the
   // assertions below, so synthesis trims them away
   logic [5:0] chk_zero;
   logic [5:0] chk_full;
   logic [5:0] chk_one;
   logic [LDR_NUM_CH*LDR_REG_W-1:0] regs_flat;

   // flattened copy lets one $stable watch all six registers at once
   always_comb begin
      for (int i = 0; i < LDR_NUM_CH; i++) begin
         chk_zero[i] = (act_duty[i] == LDR_DUTY_OFF);
         chk_full[i] = (act_duty[i] == LDR_DUTY_FULL);
         chk_one[i] = (act_duty[i] == 12'h001);
         regs_flat[i*LDR_REG_W +: LDR_REG_W] = regs[i];
      end
   end

   // code one: lit on the first count of a period, dark on the next
   sequence s_one_lit;
      (dim_out & chk_one) == chk_one;
   endsequence

   sequence s_one_dark;
      (dim_out & chk_one) == 6'h00;
   endsequence

   // zero code never lights, anywhere in the period, on any channel
   property p_zero_off;
      @(posedge ref_clk) disable iff (!rst_b)
         (dim_out & chk_zero) == 6'h00;
   endproperty
   a_zero_off: assert property (p_zero_off) else $error("zero code lit");

   // all-ones code stays lit through the wrap as well
   property p_full_on;
      @(posedge ref_clk) disable iff (!rst_b)
         (dim_out & chk_full) == chk_full;
   endproperty
   a_full_on: assert property (p_full_on) else $error("full code dark");

   // one count out of 4095, on whichever channels hold code one
   property p_one_count;
      @(posedge ref_clk) disable iff (!rst_b)
         period_start |-> s_one_lit ##1 s_one_dark;
   endproperty
   a_one_count: assert property (p_one_count) else $error("code one width");

   // channel 10 disable flag follows bit 12 of the last write; dim_out is not gated by it
   property p_dis_bit;
      @(posedge ref_clk) disable iff (!rst_b)
         (reg_wr && sel == 3'h3) |=> (dim_disabled[3] == $past(reg_wdata[12]));
   endproperty
   a_dis_bit: assert property (p_dis_bit) else $error("disable bit");

   // same for every mapped channel, indexed by the written address
   property p_dis_any;
      @(posedge ref_clk) disable iff (!rst_b)
         (reg_wr && reg_hit) |=> (dim_disabled[$past(sel)] == $past(reg_wdata[LDR_DIS_BIT]));
   endproperty
   a_dis_any: assert property (p_dis_any) else $error("disable bit any");

   property p_readback;
      @(posedge ref_clk) disable iff (!rst_b)
         (reg_wr && reg_hit) ##1 (reg_addr == $past(reg_addr) && !reg_wr)
            |-> reg_rdata == $past(reg_wdata);
   endproperty
   a_readback: assert property (p_readback) else $error("readback");

   property p_unmapped;
      @(posedge ref_clk) disable iff (!rst_b)
         !reg_hit |-> reg_rdata == 13'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");

   property p_hold_mid;
      @(posedge ref_clk) disable iff (!rst_b)
         !period_start |=> $stable(act_duty[4]) || period_start;
   endproperty
   a_hold_mid: assert property (p_hold_mid) else $error("mid-period load");

   property p_wrap;
      @(posedge ref_clk) disable iff (!rst_b)
         (cnt == LDR_CNT_LAST) |=> period_start;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter wrap");

   // a write outside the bank must not land in any register
   property p_no_alias;
      @(posedge ref_clk) disable iff (!rst_b)
         (reg_wr && !reg_hit) |=> $stable(regs_flat);
   endproperty
   a_no_alias: assert property (p_no_alias) else $error("unmapped write stored");

   // without a write strobe every register keeps its value
   property p_idle_hold;
      @(posedge ref_clk) disable iff (!rst_b)
         !reg_wr |=> $stable(regs_flat);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("register drift");

   // the boundary marker lasts exactly one cycle
   property p_start_pulse;
      @(posedge ref_clk) disable iff (!rst_b)
         period_start |=> !period_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");

   // free-running counter: one step per clock away from the wrap
   property p_count_step;
      @(posedge ref_clk) disable iff (!rst_b)
         (cnt != LDR_CNT_LAST) |=> (cnt == $past(cnt) + 12'h001);
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter step");

   // the all-ones count is never reached, so a period has 4095 steps
   property p_count_range;
      @(posedge ref_clk) disable iff (!rst_b)
         cnt <= LDR_CNT_LAST;
   endproperty
   a_count_range: assert property (p_count_range) else $error("counter range");
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/* bench for ldr_bank: reset values, readback, unmapped access, waveform counts,
   mid-period rewrite and mid-run reset.
   assumes the 25 MHz clock and asynchronous active-low reset of the bank. */
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import ldr_pkg::*;
;
   // ----------------------------------------
   // stimulus and observation
   // ----------------------------------------
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [12:0] reg_wdata = 13'h0000;
   logic [12:0] reg_rdata;
   logic reg_hit;
   logic [5:0] dim_out;
   logic [5:0] dim_disabled;
   logic period_start;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;
   always #20 ref_clk = ~ref_clk;
   ldr_bank ldr_bank_i (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .dim_out(dim_out),
      .dim_disabled(dim_disabled), .period_start(period_start));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask
   // one-cycle strobe, driven off the sampling edge
   task automatic wr(input logic [7:0] a, input logic [12:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   // read is combinational, so settle a few ns then look
   task automatic rd_chk(input logic [7:0] a, input logic [12:0] exp);
      @(negedge ref_clk);
      reg_addr = a;
      #5;
      chk("rdata", exp, reg_rdata);
      chk("hit", 13'(a >= 8'h48 && a <= 8'h4d), 13'(reg_hit));
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [12:0] v [6];
      for (int i = 0; i < 6; i++) rd_chk(LDR_ADDR_CH7 + 8'(i), LDR_REG_RESET);
      for (int i = 0; i < 6; i++) begin
         v[i] = 13'(i * 1365) ^ (i[0] ? 13'h1000 : 13'h0000);
         wr(LDR_ADDR_CH7 + 8'(i), v[i]);
      end
      // neighbours outside the bank must neither store nor alias
      wr(8'h47, 13'h1fff);
      wr(8'h4e, 13'h1fff);
      for (int i = 0; i < 6; i++) rd_chk(LDR_ADDR_CH7 + 8'(i), v[i]);
      rd_chk(8'h47, 13'h0000);
      rd_chk(8'h4e, 13'h0000);
      // bit 12 of the values above is set for channels 8, 10 and 11
      chk("disabled", 13'h001a, 13'(dim_disabled));
   endtask
   // one full period counted from its first cycle
   task automatic t_wave();
      int hi [6];
      int ps;
      logic [11:0] d [6] = '{12'h001, 12'h000, 12'hfff, 12'h003, 12'h800, 12'hffe};
      for (int i = 0; i < 6; i++) wr(LDR_ADDR_CH7 + 8'(i), {i == 3, d[i]});
      while (period_start !== 1'b0) @(negedge ref_clk);
      while (period_start !== 1'b1) @(negedge ref_clk);
      ps = 0;
      for (int i = 0; i < 6; i++) hi[i] = 0;
      repeat (4095) begin
         ps += int'(period_start === 1'b1);
         for (int i = 0; i < 6; i++) hi[i] += int'(dim_out[i] === 1'b1);
         @(negedge ref_clk);
      end
      chk("period_start", 13'd1, 13'(ps));
      for (int i = 0; i < 6; i++) chk("on_count", 13'(d[i]), 13'(hi[i]));
   endtask
   // a code written mid-period must wait for the next boundary
   task automatic t_shadow();
      int hi;
      hi = 0;
      while (period_start !== 1'b1) @(negedge ref_clk);
      repeat (10) @(negedge ref_clk);
      wr(LDR_ADDR_CH7, 13'h0fff);
      while (period_start !== 1'b1) begin
         hi += int'(dim_out[0] === 1'b1);
         @(negedge ref_clk);
      end
      chk("old_code_hold", 13'h0000, 13'(hi));
      chk("new_code_start", 13'h0001, 13'(dim_out[0]));
   endtask
   // asynchronous reset in mid-run clears registers, counter, dim_out and dim_disabled, and raises period_start
   task automatic t_midreset();
      wr(LDR_ADDR_CH9, 13'h1abc);
      rd_chk(LDR_ADDR_CH9, 13'h1abc);
      @(negedge ref_clk);
      rst_b = 1'b0;
      #5;
      chk("rst_dim_out", 13'h0000, 13'(dim_out));
      chk("rst_period_start", 13'h0001, 13'(period_start));
      chk("rst_disabled", 13'h0000, 13'(dim_disabled));
      repeat (3) @(negedge ref_clk);
      rst_b = 1'b1;
      for (int i = 0; i < 6; i++) rd_chk(LDR_ADDR_CH7 + 8'(i), LDR_REG_RESET);
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      repeat (12) @(negedge ref_clk);
      rst_b = 1'b1;
      t_regs();
      t_wave();
      t_shadow();
      t_midreset();
      complete_run();
   end
endmodule
`default_nettype wire
